// ===== core/pmc_pkg.sv
// Constants, register map and mode type for the power-mode clock controller
package pmc_pkg;

  // Special-function register addresses
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] ADDR_CLOCK_SELECT = 8'h8f;
  localparam logic [7:0] ADDR_WAKE_MASK = 8'h9f;
  localparam logic [7:0] ADDR_POWER_MANAGE = 8'hc4;
  localparam logic [7:0] ADDR_TIMED_ACCESS = 8'hc9;

  // Values after reset
  localparam logic [7:0] CLOCK_SELECT_RST = 8'h98;
  localparam logic [7:0] WAKE_MASK_RST = 8'hff;
  localparam logic [7:0] POWER_MANAGE_RST = 8'h40;
  localparam logic [2:0] POWER_CONTROL_RST = 3'h0;

  // Field positions
  localparam int PC_SLEEP_BIT = 2;
  localparam int PC_STOP_BIT = 1;
  localparam int PC_IDLE_BIT = 0;
  localparam int PM_CTRL_HI_BIT = 7;
  localparam int PM_CTRL_LO_BIT = 6;
  localparam int PM_SWITCH_BACK_BIT = 5;
  localparam int CS_PREDIV_LSB = 4;
  localparam int CS_SETTLE_LSB = 2;

  // Timed-access window keys
  localparam logic [7:0] TA_KEY_FIRST = 8'haa;
  localparam logic [7:0] TA_KEY_SECOND = 8'h55;
  localparam logic [7:0] TA_KEY_CLOSE = 8'h00;
  localparam logic [8:0] TA_WINDOW_CYCLES = 9'h100;

  // Regulator settling: base count, doubled per selection step
  localparam logic [9:0] SETTLE_BASE_CYCLES = 10'h040;

  // Wake sources: pin0, pin1, lines 2, 3, 4, 7, 8
  localparam int WAKE_SRC = 7;
  localparam logic [6:0] WAKE_ACTIVE_LOW = 7'h03;

  typedef enum logic [2:0] {
    MODE_RUN,
    MODE_IDLE,
    MODE_STOP,
    MODE_SLEEP,
    MODE_SETTLE
  } pmode_t;

  // System clock ratio for each pre-divider code
  function automatic logic [10:0] prediv_ratio(input logic [3:0] code);
    logic [10:0] r;
    r = 11'h001;
    if (code == 4'h0) begin
      r = 11'h001;
    end else if (code <= 4'h7) begin
      r = {6'h00, code, 1'b0};
    end else if (code == 4'h8) begin
      r = 11'h00f;
    end else begin
      r = 11'h010 << (code - 4'h9);
    end
    return r;
  endfunction

endpackage

// ===== core/clock_prediv.sv
// Internal oscillator pre-divider producing the system clock enable
module clock_prediv (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic run_in,
  input wire logic [3:0] prediv_in,
  output logic sys_en_out
);

  logic [10:0] count_reg;
  logic [10:0] ratio_reg;
  logic wrap;

  assign wrap = (count_reg + 11'h001) >= ratio_reg;

  // Ratio reloads only at a period boundary or while stopped, so no pulse is cut short
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      count_reg <= 11'h000;
      ratio_reg <= pmc_pkg::prediv_ratio(pmc_pkg::CLOCK_SELECT_RST[7:4]);
      sys_en_out <= 1'b0;
    end else if (!run_in) begin
      count_reg <= 11'h000;
      ratio_reg <= pmc_pkg::prediv_ratio(prediv_in);
      sys_en_out <= 1'b0;
    end else if (wrap) begin
      count_reg <= 11'h000;
      ratio_reg <= pmc_pkg::prediv_ratio(prediv_in);
      sys_en_out <= 1'b1;
    end else begin
      count_reg <= count_reg + 11'h001;
      sys_en_out <= 1'b0;
    end
  end

endmodule

// ===== core/wake_detect.sv
// Synchronises wake sources and turns their active edge into a pulse
module wake_detect #(
  parameter int N = pmc_pkg::WAKE_SRC,
  parameter logic [6:0] ACTIVE_LOW = pmc_pkg::WAKE_ACTIVE_LOW
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic [N-1:0] src_in,
  output logic [N-1:0] edge_out
);

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_src
      logic meta_reg;
      logic sync_reg;
      logic prev_reg;
      logic active;
      assign active = ACTIVE_LOW[i] ? ~sync_reg : sync_reg;
      always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
          meta_reg <= ACTIVE_LOW[i];
          sync_reg <= ACTIVE_LOW[i];
          prev_reg <= 1'b0;
          edge_out[i] <= 1'b0;
        end else begin
          meta_reg <= src_in[i];
          sync_reg <= meta_reg;
          prev_reg <= active;
          // Edge even for level-set interrupts
          edge_out[i] <= active & ~prev_reg;
        end
      end
    end
  endgenerate

endmodule

// ===== core/power_mode_clock_control.sv
// Power-mode sequencer, clock selection and wake gating with its registers
// Notes on behaviour
// - Sleep and stop bits both set: gate CPU and peripheral clocks, enter Sleep.
// - Leaving Sleep clears sleep and stop bits in hardware.
// - Sleep also turns regulator off; wake waits regulator settling.
// - Stop bit alone set: CPU and peripheral clocks stop, Stop mode.
// - Stop ends only on reset, a pin or a clock-free interrupt.
// - Stop bit cleared automatically on Stop exit.
// - Idle stops CPU clock, resets core peripherals, outer clocks keep running.
// - Idle exits on enabled interrupts or switch-back activity; idle bit cleared by hardware then.
// - Upper divider control bit always reads zero; no reduced speed.
// - Writable switch-back bit; peripheral activity then returns to normal.
// - Four-bit pre-divider selects system clock ratio from oscillator.
// - Two-bit field selects 64, 128, 256 or 512 settling cycles.
// - Clock selection writes only accepted while timed window open.
// - Wake-mask bit per source allows Stop wake; all reset enabled.
// - Enabled wake source restarts oscillator and system clock.
// - Wake detection always acts on the signal edge.
// - Stop and Sleep wake independent of interrupt enable; disabled source skips vectoring.
// - In Stop only pins and clock-free sources may wake.
// - Idle exits on enabled external or OR-ed peripheral interrupts.
// - On Idle exit by an interrupt the CPU vectors at once to the waking routine.
// - During Idle no CPU processing; core peripherals inaccessible.
// - Unlock sequence opens protected writes for 256 clock periods.
// - Pins wake on falling edge, peripheral flags on rising edge.
module power_mode_clock_control (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [1:0] ext_pin_n_in,
  input wire logic [4:0] clockfree_irq_in,
  input wire logic [6:0] irq_enable_in,
  input wire logic periph_irq_in,
  input wire logic periph_activity_in,
  output logic [7:0] sfr_rdata_out,
  output logic sys_clk_en_out,
  output logic cpu_clk_en_out,
  output logic periph_clk_en_out,
  output logic core_periph_rst_out,
  output logic core_access_block_out,
  output logic osc_on_out,
  output logic regulator_on_out,
  output logic cpu_hold_out,
  output logic vector_req_out,
  output logic [6:0] wake_src_out,
  output logic window_open_out
);

  pmc_pkg::pmode_t mode_reg;
  pmc_pkg::pmode_t mode_next;
  logic [2:0] power_control_reg;
  logic [7:0] clock_select_reg;
  logic [7:0] wake_mask_reg;
  logic ctrl_lo_reg;
  logic switch_back_reg;
  logic key_seen_reg;
  logic [8:0] window_cnt_reg;
  logic [9:0] settle_cnt_reg;
  logic [9:0] settle_cnt_next;
  logic [6:0] pending_src_reg;
  logic [6:0] pending_src_next;
  logic sys_en;
  logic [6:0] wake_edge;

  // Address decode
  logic wr_power_control, wr_csel, wr_wmask, wr_pmr, wr_ta;
  assign wr_power_control = sfr_wr_in && (sfr_addr_in == pmc_pkg::ADDR_POWER_CONTROL);
  assign wr_csel = sfr_wr_in && (sfr_addr_in == pmc_pkg::ADDR_CLOCK_SELECT);
  assign wr_wmask = sfr_wr_in && (sfr_addr_in == pmc_pkg::ADDR_WAKE_MASK);
  assign wr_pmr = sfr_wr_in && (sfr_addr_in == pmc_pkg::ADDR_POWER_MANAGE);
  assign wr_ta = sfr_wr_in && (sfr_addr_in == pmc_pkg::ADDR_TIMED_ACCESS);

  logic window_open;
  assign window_open = (window_cnt_reg != 9'h000);

  // Protected writes need an open window
  logic csel_we, wmask_we;
  assign csel_we = wr_csel && window_open;
  assign wmask_we = wr_wmask && window_open;

  // Wake source enables: pins 0..1 and lines 2,3,4 then 7,8
  logic [6:0] wake_en;
  assign wake_en = {wake_mask_reg[7:6], wake_mask_reg[4:0]};

  // Stop and Sleep wake: mask only, never the clocked peripheral request
  logic [6:0] stop_hit;
  logic stop_wake;
  assign stop_hit = wake_edge & wake_en;
  assign stop_wake = |stop_hit;

  // Idle wake: enabled interrupts, with peripheral requests OR-ed in
  logic [6:0] idle_hit;
  logic idle_wake;
  assign idle_hit = wake_edge & irq_enable_in;
  assign idle_wake = (|idle_hit) || periph_irq_in ||
                     (switch_back_reg && periph_activity_in);

  logic [9:0] settle_load;
  assign settle_load = pmc_pkg::SETTLE_BASE_CYCLES <<
                       clock_select_reg[pmc_pkg::CS_SETTLE_LSB +: 2];

  logic osc_run;
  assign osc_run = (mode_reg != pmc_pkg::MODE_STOP) && (mode_reg != pmc_pkg::MODE_SLEEP);

  always_comb begin
    mode_next = mode_reg;
    settle_cnt_next = settle_cnt_reg;
    pending_src_next = pending_src_reg;
    unique case (mode_reg)
      pmc_pkg::MODE_RUN: begin
        pending_src_next = 7'h00;
        if (wr_power_control && sfr_wdata_in[pmc_pkg::PC_STOP_BIT]) begin
          if (sfr_wdata_in[pmc_pkg::PC_SLEEP_BIT]) begin
            mode_next = pmc_pkg::MODE_SLEEP;
          end else begin
            mode_next = pmc_pkg::MODE_STOP;
          end
        end else if (wr_power_control && sfr_wdata_in[pmc_pkg::PC_IDLE_BIT]) begin
          mode_next = pmc_pkg::MODE_IDLE;
        end
      end
      pmc_pkg::MODE_IDLE: begin
        if (idle_wake) begin
          mode_next = pmc_pkg::MODE_RUN;
          pending_src_next = idle_hit;
        end
      end
      pmc_pkg::MODE_STOP: begin
        if (stop_wake) begin
          mode_next = pmc_pkg::MODE_RUN;
          pending_src_next = stop_hit;
        end
      end
      pmc_pkg::MODE_SLEEP: begin
        if (stop_wake) begin
          mode_next = pmc_pkg::MODE_SETTLE;
          settle_cnt_next = settle_load;
          pending_src_next = stop_hit;
        end
      end
      pmc_pkg::MODE_SETTLE: begin
        settle_cnt_next = settle_cnt_reg - 10'h001;
        if (settle_cnt_reg <= 10'h001) begin
          mode_next = pmc_pkg::MODE_RUN;
        end
      end
      default: begin
        mode_next = pmc_pkg::MODE_SETTLE;
      end
    endcase
  end

  logic exiting;
  assign exiting = (mode_reg != pmc_pkg::MODE_RUN) && (mode_next == pmc_pkg::MODE_RUN);

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      mode_reg <= pmc_pkg::MODE_SETTLE;
      settle_cnt_reg <= pmc_pkg::SETTLE_BASE_CYCLES << pmc_pkg::CLOCK_SELECT_RST[3:2];
      pending_src_reg <= 7'h00;
    end else begin
      mode_reg <= mode_next;
      settle_cnt_reg <= settle_cnt_next;
      pending_src_reg <= pending_src_next;
    end
  end

  // Mode bits follow the sequencer; hardware clears them on any exit
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      power_control_reg <= pmc_pkg::POWER_CONTROL_RST;
    end else if (mode_next == pmc_pkg::MODE_RUN || mode_next == pmc_pkg::MODE_SETTLE) begin
      power_control_reg <= 3'h0;
    end else if (wr_power_control && mode_reg == pmc_pkg::MODE_RUN) begin
      power_control_reg <= sfr_wdata_in[2:0];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      clock_select_reg <= pmc_pkg::CLOCK_SELECT_RST;
      wake_mask_reg <= pmc_pkg::WAKE_MASK_RST;
      ctrl_lo_reg <= pmc_pkg::POWER_MANAGE_RST[pmc_pkg::PM_CTRL_LO_BIT];
      switch_back_reg <= pmc_pkg::POWER_MANAGE_RST[pmc_pkg::PM_SWITCH_BACK_BIT];
    end else begin
      if (csel_we) begin
        clock_select_reg <= {sfr_wdata_in[7:2], 2'b00};
      end
      if (wmask_we) begin
        wake_mask_reg <= sfr_wdata_in;
      end
      if (wr_pmr) begin
        ctrl_lo_reg <= sfr_wdata_in[pmc_pkg::PM_CTRL_LO_BIT];
        switch_back_reg <= sfr_wdata_in[pmc_pkg::PM_SWITCH_BACK_BIT];
      end
    end
  end

  // Window counts system clock periods; a repeated unlock restarts it
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      key_seen_reg <= 1'b0;
      window_cnt_reg <= 9'h000;
    end else if (wr_ta) begin
      key_seen_reg <= (sfr_wdata_in == pmc_pkg::TA_KEY_FIRST);
      if (sfr_wdata_in == pmc_pkg::TA_KEY_CLOSE) begin
        window_cnt_reg <= 9'h000;
      end else if (key_seen_reg && sfr_wdata_in == pmc_pkg::TA_KEY_SECOND) begin
        window_cnt_reg <= pmc_pkg::TA_WINDOW_CYCLES;
      end
    end else if (window_open && sys_en) begin
      window_cnt_reg <= window_cnt_reg - 9'h001;
    end
  end

  // Read mux; write-only power control reads zero
  logic [7:0] rd_mux;
  assign rd_mux =
    (sfr_addr_in == pmc_pkg::ADDR_CLOCK_SELECT) ? clock_select_reg :
    (sfr_addr_in == pmc_pkg::ADDR_WAKE_MASK) ? wake_mask_reg :
    (sfr_addr_in == pmc_pkg::ADDR_POWER_MANAGE) ?
      {1'b0, ctrl_lo_reg, switch_back_reg, 5'h00} :
    (sfr_addr_in == pmc_pkg::ADDR_TIMED_ACCESS) ? {7'h00, window_open} :
    8'h00;

  logic run_now, idle_now;
  assign run_now = (mode_next == pmc_pkg::MODE_RUN);
  assign idle_now = (mode_next == pmc_pkg::MODE_IDLE);

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      sfr_rdata_out <= 8'h00;
      sys_clk_en_out <= 1'b0;
      cpu_clk_en_out <= 1'b0;
      periph_clk_en_out <= 1'b0;
      core_periph_rst_out <= 1'b0;
      core_access_block_out <= 1'b0;
      osc_on_out <= 1'b1;
      regulator_on_out <= 1'b1;
      cpu_hold_out <= 1'b1;
      vector_req_out <= 1'b0;
      wake_src_out <= 7'h00;
      window_open_out <= 1'b0;
    end else begin
      sfr_rdata_out <= sfr_rd_in ? rd_mux : sfr_rdata_out;
      sys_clk_en_out <= sys_en;
      cpu_clk_en_out <= sys_en && run_now;
      periph_clk_en_out <= sys_en && (run_now || idle_now);
      core_periph_rst_out <= idle_now;
      core_access_block_out <= idle_now;
      osc_on_out <= osc_run;
      regulator_on_out <= (mode_next != pmc_pkg::MODE_SLEEP);
      cpu_hold_out <= !run_now && !idle_now && (mode_next == pmc_pkg::MODE_SETTLE);
      // Vector only if the waking source is enabled
      vector_req_out <= exiting && ((|(pending_src_next & irq_enable_in)) ||
                        (mode_reg == pmc_pkg::MODE_IDLE && periph_irq_in));
      wake_src_out <= exiting ? pending_src_next : wake_src_out;
      window_open_out <= window_open;
    end
  end

  clock_prediv i_clock_prediv (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .run_in(osc_run),
    .prediv_in(clock_select_reg[pmc_pkg::CS_PREDIV_LSB +: 4]),
    .sys_en_out(sys_en)
  );

  wake_detect i_wake_detect (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .src_in({clockfree_irq_in, ext_pin_n_in}),
    .edge_out(wake_edge)
  );

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);

  sequence s_enter_sleep;
    mode_reg == pmc_pkg::MODE_RUN && wr_power_control && sfr_wdata_in[2:1] == 2'b11;
  endsequence

  chk_sleep_entry: assert property (s_enter_sleep |=>
    mode_reg == pmc_pkg::MODE_SLEEP ##1 !cpu_clk_en_out && !periph_clk_en_out)
    else $error("sleep entry failed");
  chk_sleep_clear: assert property ($fell(mode_reg == pmc_pkg::MODE_SLEEP) |->
    power_control_reg == 3'h0) else $error("sleep bits not cleared");
  // Same-cycle check: the regulator comes back on the wake edge itself
  chk_sleep_reg_off: assert property (mode_reg == pmc_pkg::MODE_SLEEP |->
    !regulator_on_out) else $error("regulator on in sleep");
  chk_stop_entry: assert property (mode_reg == pmc_pkg::MODE_RUN && wr_power_control &&
    sfr_wdata_in[2:1] == 2'b01 |=> mode_reg == pmc_pkg::MODE_STOP)
    else $error("stop entry failed");
  chk_stop_hold: assert property (mode_reg == pmc_pkg::MODE_STOP && !stop_wake |=>
    mode_reg == pmc_pkg::MODE_STOP) else $error("stop left without wake");
  chk_stop_clear: assert property (mode_reg == pmc_pkg::MODE_STOP && stop_wake |=>
    power_control_reg[1] == 1'b0 && mode_reg == pmc_pkg::MODE_RUN) else $error("stop bit kept");
  chk_idle_rst: assert property (mode_reg == pmc_pkg::MODE_IDLE |->
    core_periph_rst_out && !cpu_clk_en_out) else $error("idle core reset missing");
  chk_ctrl_hi_zero: assert property (sfr_rd_in &&
    sfr_addr_in == pmc_pkg::ADDR_POWER_MANAGE |=> sfr_rdata_out[7] == 1'b0)
    else $error("divider control high bit set");
  chk_csel_locked: assert property (wr_csel && !window_open |=>
    $stable(clock_select_reg)) else $error("locked clock select changed");
  // A close key may end the window at once, so check load and countdown instead
  chk_window_len: assert property ($rose(window_open) |->
    window_cnt_reg == pmc_pkg::TA_WINDOW_CYCLES) else $error("window length wrong");
  chk_window_tick: assert property (window_open && !wr_ta && sys_en |=>
    window_cnt_reg == $past(window_cnt_reg) - 9'h001) else $error("window count skipped");
  chk_settle_time: assert property (mode_reg == pmc_pkg::MODE_SLEEP && stop_wake |=>
    settle_cnt_reg == settle_load ##0 mode_reg == pmc_pkg::MODE_SETTLE [*8])
    else $error("settle delay wrong");

endmodule

// ===== verification/power_mode_clock_control_tb_top.sv
// Self-checking testbench for the power-mode clock controller
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
  $display("[ERR] %0t value mismatch got %0h exp %0h", $time, a, b); end end
module power_mode_clock_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [1:0] ext_pin_n = 2'h3;
  logic [4:0] clockfree_irq = 5'h00;
  logic [6:0] irq_enable = 7'h7f;
  logic periph_irq = 1'b0;
  logic periph_activity = 1'b0;
  logic [7:0] sfr_rdata_out;
  logic sys_clk_en_out, cpu_clk_en_out, periph_clk_en_out, core_periph_rst_out;
  logic core_access_block_out, osc_on_out, regulator_on_out, cpu_hold_out;
  logic vector_req_out, window_open_out;
  logic [6:0] wake_src_out;
  int fails = 0;
  int n_compared = 0;
  int n_vec = 0;
  int n_cpu = 0;
  int n_per = 0;

  always #12.5 mclk_in = ~mclk_in;

  power_mode_clock_control i_power_mode_clock_control (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .sfr_addr_in(sfr_addr),
    .sfr_wdata_in(sfr_wdata), .sfr_wr_in(sfr_wr), .sfr_rd_in(sfr_rd),
    .ext_pin_n_in(ext_pin_n), .clockfree_irq_in(clockfree_irq),
    .irq_enable_in(irq_enable), .periph_irq_in(periph_irq),
    .periph_activity_in(periph_activity), .sfr_rdata_out(sfr_rdata_out),
    .sys_clk_en_out(sys_clk_en_out), .cpu_clk_en_out(cpu_clk_en_out),
    .periph_clk_en_out(periph_clk_en_out), .core_periph_rst_out(core_periph_rst_out),
    .core_access_block_out(core_access_block_out), .osc_on_out(osc_on_out),
    .regulator_on_out(regulator_on_out), .cpu_hold_out(cpu_hold_out),
    .vector_req_out(vector_req_out), .wake_src_out(wake_src_out),
    .window_open_out(window_open_out)
  );

  // Pulse outputs last one cycle, so they are tallied at every edge
  always @(posedge mclk_in) begin
    if (vector_req_out === 1'b1) n_vec++;
    if (cpu_clk_en_out === 1'b1) n_cpu++;
    if (periph_clk_en_out === 1'b1) n_per++;
  end

  task conclude;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task give_up;
    fails++;
    $display("[ERR] %0t wait ran out", $time);
    conclude();
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge mclk_in);
    sfr_wr <= 1'b0;
  endtask

  task rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk_in);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge mclk_in);
    sfr_rd <= 1'b0;
    @(posedge mclk_in);
    @(negedge mclk_in);
    `CHK(sfr_rdata_out, e)
  endtask

  task prot_wr(input logic [7:0] a, input logic [7:0] d);
    wr(pmc_pkg::ADDR_TIMED_ACCESS, pmc_pkg::TA_KEY_FIRST);
    wr(pmc_pkg::ADDR_TIMED_ACCESS, pmc_pkg::TA_KEY_SECOND);
    wr(a, d);
    wr(pmc_pkg::ADDR_TIMED_ACCESS, pmc_pkg::TA_KEY_CLOSE);
  endtask

  task wait_run;
    int k;
    k = 0;
    while (!(cpu_hold_out === 1'b0 && osc_on_out === 1'b1 &&
             core_periph_rst_out === 1'b0) && k < 3000) begin
      @(negedge mclk_in);
      k++;
    end
    if (k >= 3000) give_up();
  endtask

  task hold_len(input int e);
    int k;
    int n;
    k = 0;
    n = 0;
    while (cpu_hold_out !== 1'b1 && k < 40) begin @(negedge mclk_in); k++; end
    while (cpu_hold_out === 1'b1 && n < 3000) begin @(negedge mclk_in); n++; end
    if (k >= 40 || n >= 3000) give_up();
    `CHK(n >= e - 2 && n <= e + 4, 1'b1)
  endtask

  task period(output int p);
    int k;
    k = 0;
    while (sys_clk_en_out !== 1'b1 && k < 3000) begin @(negedge mclk_in); k++; end
    @(negedge mclk_in);
    p = 1;
    while (sys_clk_en_out !== 1'b1 && p < 3000) begin @(negedge mclk_in); p++; end
    if (k >= 3000 || p >= 3000) give_up();
  endtask

  task t_reset;
    hold_len(256);
    wait_run();
    rchk(pmc_pkg::ADDR_CLOCK_SELECT, 8'h98);
    rchk(pmc_pkg::ADDR_WAKE_MASK, 8'hff);
    rchk(pmc_pkg::ADDR_POWER_MANAGE, 8'h40);
    rchk(8'h55, 8'h00);
    wr(pmc_pkg::ADDR_POWER_MANAGE, 8'hc0);
    rchk(pmc_pkg::ADDR_POWER_MANAGE, 8'h40);
    wr(pmc_pkg::ADDR_POWER_MANAGE, 8'h60);
    rchk(pmc_pkg::ADDR_POWER_MANAGE, 8'h60);
    wr(pmc_pkg::ADDR_POWER_MANAGE, 8'h40);
  endtask

  task t_window;
    wr(pmc_pkg::ADDR_CLOCK_SELECT, 8'h00);
    rchk(pmc_pkg::ADDR_CLOCK_SELECT, 8'h98);
    wr(pmc_pkg::ADDR_TIMED_ACCESS, pmc_pkg::TA_KEY_FIRST);
    wr(pmc_pkg::ADDR_TIMED_ACCESS, pmc_pkg::TA_KEY_SECOND);
    repeat (2) @(negedge mclk_in);
    `CHK(window_open_out, 1'b1)
    wr(pmc_pkg::ADDR_CLOCK_SELECT, 8'h00);
    rchk(pmc_pkg::ADDR_CLOCK_SELECT, 8'h00);
    // Prediv now 1, so the window runs out after 256 cycles
    repeat (300) @(negedge mclk_in);
    `CHK(window_open_out, 1'b0)
    wr(pmc_pkg::ADDR_CLOCK_SELECT, 8'h98);
    rchk(pmc_pkg::ADDR_CLOCK_SELECT, 8'h00);
  endtask

  task t_prediv;
    logic [3:0] codes [6];
    int ratios [6];
    int p;
    codes = '{4'h0, 4'h1, 4'h7, 4'h8, 4'h9, 4'hf};
    ratios = '{1, 2, 14, 15, 16, 1024};
    for (int i = 0; i < 6; i++) begin
      prot_wr(pmc_pkg::ADDR_CLOCK_SELECT, {codes[i], 4'h0});
      period(p);
      period(p);
      `CHK(p, ratios[i])
    end
    prot_wr(pmc_pkg::ADDR_CLOCK_SELECT, 8'h00);
  endtask

  task t_stop;
    int c0;
    int v0;
    wr(pmc_pkg::ADDR_POWER_CONTROL, 8'h02);
    repeat (3) @(negedge mclk_in);
    c0 = n_cpu;
    `CHK(osc_on_out, 1'b0)
    periph_irq <= 1'b1;
    repeat (20) @(negedge mclk_in);
    `CHK(osc_on_out, 1'b0)
    `CHK(n_cpu - c0, 0)
    periph_irq <= 1'b0;
    v0 = n_vec;
    ext_pin_n <= 2'h2;
    wait_run();
    `CHK(n_vec - v0, 1)
    `CHK(wake_src_out, 7'h01)
    repeat (10) @(negedge mclk_in);
    `CHK(osc_on_out, 1'b1)
    wr(pmc_pkg::ADDR_POWER_CONTROL, 8'h02);
    repeat (20) @(negedge mclk_in);
    `CHK(osc_on_out, 1'b0)
    ext_pin_n <= 2'h3;
    repeat (4) @(negedge mclk_in);
    ext_pin_n <= 2'h2;
    wait_run();
    ext_pin_n <= 2'h3;
    prot_wr(pmc_pkg::ADDR_WAKE_MASK, 8'hfd);
    wr(pmc_pkg::ADDR_POWER_CONTROL, 8'h02);
    ext_pin_n <= 2'h1;
    repeat (20) @(negedge mclk_in);
    `CHK(osc_on_out, 1'b0)
    irq_enable <= 7'h7b;
    v0 = n_vec;
    clockfree_irq <= 5'h01;
    wait_run();
    `CHK(n_vec - v0, 0)
    `CHK(wake_src_out, 7'h04)
    clockfree_irq <= 5'h00;
    ext_pin_n <= 2'h3;
    irq_enable <= 7'h7f;
    prot_wr(pmc_pkg::ADDR_WAKE_MASK, 8'hff);
  endtask

  task t_sleep(input logic [7:0] csel, input int e);
    prot_wr(pmc_pkg::ADDR_CLOCK_SELECT, csel);
    wr(pmc_pkg::ADDR_POWER_CONTROL, 8'h06);
    repeat (3) @(negedge mclk_in);
    `CHK(regulator_on_out, 1'b0)
    `CHK(osc_on_out, 1'b0)
    clockfree_irq <= 5'h10;
    hold_len(e);
    wait_run();
    clockfree_irq <= 5'h00;
    repeat (10) @(negedge mclk_in);
    `CHK(regulator_on_out & osc_on_out, 1'b1)
  endtask

  task t_idle;
    int c0;
    int p0;
    int v0;
    rchk(pmc_pkg::ADDR_CLOCK_SELECT, 8'h0c);
    wr(pmc_pkg::ADDR_POWER_CONTROL, 8'h01);
    repeat (3) @(negedge mclk_in);
    `CHK(core_periph_rst_out, 1'b1)
    `CHK(core_access_block_out, 1'b1)
    c0 = n_cpu;
    p0 = n_per;
    repeat (32) @(negedge mclk_in);
    `CHK(n_per - p0, 32)
    `CHK(n_cpu - c0, 0)
    v0 = n_vec;
    periph_irq <= 1'b1;
    wait_run();
    periph_irq <= 1'b0;
    // Idle exit shows no oscillator lag; the pulse is tallied one edge later
    @(negedge mclk_in);
    `CHK(n_vec - v0, 1)
    repeat (10) @(negedge mclk_in);
    `CHK(core_periph_rst_out, 1'b0)
    // Disabled pin must not end Idle, switch-back activity must
    irq_enable <= 7'h7e;
    wr(pmc_pkg::ADDR_POWER_CONTROL, 8'h01);
    ext_pin_n <= 2'h2;
    repeat (20) @(negedge mclk_in);
    `CHK(core_periph_rst_out, 1'b1)
    wr(pmc_pkg::ADDR_POWER_MANAGE, 8'h60);
    periph_activity <= 1'b1;
    wait_run();
    periph_activity <= 1'b0;
    ext_pin_n <= 2'h3;
    irq_enable <= 7'h7f;
  endtask

  initial begin
    repeat (6) @(posedge mclk_in);
    nrst_in <= 1'b1;
    t_reset();
    t_window();
    t_prediv();
    t_stop();
    t_sleep(8'h00, 64);
    t_sleep(8'h0c, 512);
    t_idle();
    conclude();
  end
endmodule
